// ### core/hcd_top.sv
// Hall commutation decoder: input select, noise filter, Hall delay and table decode.
// Assumes Hall pins are asynchronous and all configuration ports are on clk.
//
// Operation
// R01 - Mode bit high uses Hall pins from selected source, low uses software bits.
// R02 - Filter enable low bypasses the noise filter, high passes through it.
// R03 - A 3-bit field sets the filter sampling rate.
// R04 - A 5-bit count sets consecutive equal samples; delay is count times period.
// R05 - Delay mode bit resets low, disabling delay; high enables it.
// R06 - Delay circuit initialises only on a low-to-high delay mode transition.
// R07 - Delay mode low holds both state buffers at zero.
// R08 - Delay mode high lets hardware drive the chosen timer's run bit.
// R09 - A 2-bit field picks the timer that times the Hall delay.
// R10 - Software configures the chosen timer fully before enabling delay.
// R11 - Software loads tables, timer, delay mode, then decoder enable.
// R12 - Programmed delay must not exceed one Hall step.
// R13 - Enabled, no brake: direction 0 uses forward table, 1 backward.
// R14 - Forward entries 0 to 5 follow the listed Hall state order.
// R15 - Backward entries 6 to 11 follow the same Hall state order.
// R16 - Entry bits 5 to 0 drive A top, A bottom, B, C likewise.
// R17 - Brake forces 010101 regardless of anything else.
// R18 - Decoder disabled drives all six controls low.
// R19 - Invalid Hall states drive all controls low, even when enabled.
// R20 - A setting selects 60 or 120 degree sensor decoding everywhere.
// R21 - Protection forces brake when its select is 1, all-off when 0.
`timescale 1ns/1ps
`include "hcd_defines.svh"

module hcd_top (
    input wire logic clk,
    input wire logic reset,
    input wire hcd_pkg::hcd_hall_t hall_inputs,
    input wire hcd_pkg::hcd_hall_t hall_alt_inputs,
    input wire hcd_pkg::hcd_hall_t software_hall_bits,
    input wire hcd_pkg::hcd_input_cfg_s input_cfg,
    input wire hcd_pkg::hcd_drive_ctrl_s drive_ctrl,
    input wire hcd_pkg::hcd_table_t commutation_table_entries,
    input wire logic [`HCD_TIMER_COUNT-1:0] software_timer_run,
    input wire logic [`HCD_TIMER_COUNT-1:0] timer_compare_match,
    output logic [`HCD_TIMER_COUNT-1:0] timer_run_bit,
    output hcd_pkg::hcd_gate_s gate_controls,
    output hcd_pkg::hcd_hall_t delay_state_buffer_one,
    output hcd_pkg::hcd_hall_t delay_state_buffer_two,
    output logic hall_state_valid
);
    // Pin synchroniser: both pin groups ride one 6-bit chain
    logic [5:0] sync1_reg, sync1_next;
    logic [5:0] sync2_reg, sync2_next;
    logic [5:0] sync3_reg, sync3_next;
    logic [5:0] pins_reg, pins_next;
    hcd_pkg::hcd_hall_t pin_hall;
    hcd_pkg::hcd_hall_t filtered_hall;
    hcd_pkg::hcd_hall_t hall_sel;

    always_comb begin
        sync1_next = {hall_alt_inputs, hall_inputs};
        sync2_next = sync1_reg;
        sync3_next = sync2_reg;
        // A bit is accepted only once the last two stages agree
        pins_next = (sync3_reg & ~(sync2_reg ^ sync3_reg)) | (pins_reg & (sync2_reg ^ sync3_reg));
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sync1_reg <= `HCD_SYNC_RESET;
            sync2_reg <= `HCD_SYNC_RESET;
            sync3_reg <= `HCD_SYNC_RESET;
            pins_reg <= `HCD_SYNC_RESET;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            sync3_reg <= sync3_next;
            pins_reg <= pins_next;
        end
    end

    assign pin_hall = input_cfg.filter_source_select ? pins_reg[5:3] : pins_reg[2:0]; // [R01]

    hcd_noise_filter u_filter (
        .clk(clk),
        .reset(reset),
        .raw(pin_hall),
        .enable(input_cfg.filter_enable),
        .rate_select(input_cfg.filter_sample_rate_select),
        .compare_count(input_cfg.filter_compare_count),
        .filtered(filtered_hall)
    );

    // Software bits skip the filter: they are already clean
    assign hall_sel = input_cfg.input_mode_select ? filtered_hall : software_hall_bits; // [R01]

    // Hall delay circuit
    hcd_pkg::hcd_dly_e dly_reg, dly_next;
    hcd_pkg::hcd_hall_t delay_state_buffer_one_reg, delay_state_buffer_one_next;
    hcd_pkg::hcd_hall_t delay_state_buffer_two_reg, delay_state_buffer_two_next;
    logic mode_prev_reg, mode_prev_next;
    logic [`HCD_TIMER_COUNT-1:0] run_reg, run_next;
    logic [1:0] timer_sel;
    logic mode_rise;
    logic match_sel;

    // Codes above the last timer fall onto the last timer
    assign timer_sel = (drive_ctrl.delay_timer_select > `HCD_LAST_TIMER) ?
        `HCD_LAST_TIMER : drive_ctrl.delay_timer_select; // [R09]
    assign mode_rise = drive_ctrl.delay_mode_bit && !mode_prev_reg;
    assign match_sel = timer_compare_match[timer_sel];

    always_comb begin
        dly_next = dly_reg;
        delay_state_buffer_one_next = delay_state_buffer_one_reg;
        delay_state_buffer_two_next = delay_state_buffer_two_reg;
        mode_prev_next = drive_ctrl.delay_mode_bit;
        run_next = software_timer_run;
        if (!drive_ctrl.delay_mode_bit) begin
            dly_next = hcd_pkg::HCD_DLY_OFF; // [R05]
            delay_state_buffer_one_next = `HCD_BUF_RESET; // [R07]
            delay_state_buffer_two_next = `HCD_BUF_RESET; // [R07]
        end else begin
            case (dly_reg)
                hcd_pkg::HCD_DLY_OFF: begin
                    // Setting the bit again without a low phase leaves the circuit in HCD_DLY_OFF
                    if (mode_rise) begin // [R06]
                        dly_next = hcd_pkg::HCD_DLY_IDLE;
                        delay_state_buffer_one_next = hall_sel;
                        delay_state_buffer_two_next = hall_sel;
                    end
                end
                hcd_pkg::HCD_DLY_IDLE: begin
                    if (hall_sel != delay_state_buffer_one_reg) begin
                        dly_next = hcd_pkg::HCD_DLY_RUN;
                        delay_state_buffer_one_next = hall_sel;
                    end
                end
                hcd_pkg::HCD_DLY_RUN: begin
                    // A second edge inside one delay is a misuse; the newest state wins unless it lands in the match cycle, where buffer two keeps the older state
                    if (hall_sel != delay_state_buffer_one_reg) begin
                        delay_state_buffer_one_next = hall_sel;
                    end
                    if (match_sel) begin
                        dly_next = hcd_pkg::HCD_DLY_IDLE;
                        delay_state_buffer_two_next = delay_state_buffer_one_reg;
                    end
                end
                default: begin
                    dly_next = hcd_pkg::HCD_DLY_OFF;
                end
            endcase
            // The chosen run bit stays hardware-owned even before the first rising mode edge
            if (dly_next == hcd_pkg::HCD_DLY_RUN) begin
                run_next[timer_sel] = 1'b1; // [R08]
            end else begin
                run_next[timer_sel] = 1'b0; // [R08]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            dly_reg <= hcd_pkg::HCD_DLY_OFF;
            delay_state_buffer_one_reg <= `HCD_BUF_RESET;
            delay_state_buffer_two_reg <= `HCD_BUF_RESET;
            mode_prev_reg <= 1'b1;
            run_reg <= `HCD_TIMER_RESET;
        end else begin
            dly_reg <= dly_next;
            delay_state_buffer_one_reg <= delay_state_buffer_one_next;
            delay_state_buffer_two_reg <= delay_state_buffer_two_next;
            mode_prev_reg <= mode_prev_next;
            run_reg <= run_next;
        end
    end

    assign timer_run_bit = run_reg;
    assign delay_state_buffer_one = delay_state_buffer_one_reg;
    assign delay_state_buffer_two = delay_state_buffer_two_reg;

    // Commutation decode
    hcd_pkg::hcd_hall_t decode_state;
    logic [2:0] hall_idx;
    hcd_pkg::hcd_entry_t gate_reg, gate_next;
    logic valid_reg, valid_next;

    // Without delay the decoder sees the selected Hall state directly
    assign decode_state = drive_ctrl.delay_mode_bit ? delay_state_buffer_two_reg : hall_sel;
    assign hall_idx = hcd_pkg::hcd_hall_index(decode_state, input_cfg.sensor_120_select); // [R20]

    always_comb begin
        valid_next = hall_idx != `HCD_IDX_BAD;
        gate_next = `HCD_GATE_OFF;
        if (drive_ctrl.brake_force) begin
            gate_next = `HCD_GATE_BRAKE; // [R17]
        end else if (drive_ctrl.protection_active) begin
            gate_next = drive_ctrl.protection_brake_select ?
                `HCD_GATE_BRAKE : `HCD_GATE_OFF; // [R21]
        end else if (hall_idx == `HCD_IDX_BAD) begin
            gate_next = `HCD_GATE_OFF; // [R19]
        end else if (!drive_ctrl.decoder_enable) begin
            gate_next = `HCD_GATE_OFF; // [R18]
        end else begin
            // [R13] [R14] [R15]
            gate_next = commutation_table_entries[
                hcd_pkg::hcd_table_slot(drive_ctrl.rotation_direction, hall_idx)];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            gate_reg <= `HCD_GATE_OFF;
            valid_reg <= 1'b0;
        end else begin
            gate_reg <= gate_next;
            valid_reg <= valid_next;
        end
    end

    assign gate_controls = hcd_pkg::hcd_gate_s'(gate_reg); // [R16]
    assign hall_state_valid = valid_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence drive_normal_s;
        !drive_ctrl.brake_force && !drive_ctrl.protection_active && drive_ctrl.decoder_enable
            && hall_idx != `HCD_IDX_BAD;
    endsequence

    sequence delay_start_s;
        !drive_ctrl.delay_mode_bit ##1 drive_ctrl.delay_mode_bit;
    endsequence

    brake_force_out_a: assert property (drive_ctrl.brake_force |=> gate_reg == `HCD_GATE_BRAKE
        && gate_controls.phase_a_bottom && !gate_controls.phase_a_top) // [R17]
        else $error("Brake did not force bottoms on and tops off");

    protect_out_a: assert property (!drive_ctrl.brake_force && drive_ctrl.protection_active
        |=> gate_reg == ($past(drive_ctrl.protection_brake_select) ?
        `HCD_GATE_BRAKE : `HCD_GATE_OFF)) // [R21]
        else $error("Protection pattern does not match its select");

    decoder_off_a: assert property (!drive_ctrl.brake_force && !drive_ctrl.protection_active
        && !drive_ctrl.decoder_enable |=> gate_reg == `HCD_GATE_OFF) // [R18]
        else $error("Disabled decoder drove a gate control");

    invalid_state_a: assert property (!drive_ctrl.brake_force && !drive_ctrl.protection_active
        && hall_idx == `HCD_IDX_BAD |=> gate_reg == `HCD_GATE_OFF && !hall_state_valid) // [R19]
        else $error("Invalid Hall state drove a gate control");

    forward_table_a: assert property (drive_normal_s ##0 !drive_ctrl.rotation_direction
        |=> gate_reg == commutation_table_entries[$past(hall_idx)]) // [R14]
        else $error("Forward table entry not driven");

    backward_table_a: assert property (drive_normal_s ##0 drive_ctrl.rotation_direction
        |=> gate_reg == commutation_table_entries[4'(6 + $past(hall_idx))]) // [R15]
        else $error("Backward table entry not driven");

    sixty_bad_a: assert property (!input_cfg.sensor_120_select
        && (decode_state == 3'h5 || decode_state == 3'h2) |-> hall_idx == `HCD_IDX_BAD) // [R20]
        else $error("60 degree invalid state not flagged");

    buffers_clear_a: assert property (!drive_ctrl.delay_mode_bit
        |=> delay_state_buffer_one == `HCD_BUF_RESET
        && delay_state_buffer_two == `HCD_BUF_RESET) // [R07]
        else $error("Delay buffers not cleared while delay is off");

    delay_init_a: assert property (delay_start_s
        |=> dly_reg == hcd_pkg::HCD_DLY_IDLE && delay_state_buffer_two_reg == $past(hall_sel)) // [R06]
        else $error("Delay circuit not initialised on the rising mode bit");

    no_reinit_a: assert property (dly_reg == hcd_pkg::HCD_DLY_OFF && $past(drive_ctrl.delay_mode_bit)
        && drive_ctrl.delay_mode_bit |=> dly_reg == hcd_pkg::HCD_DLY_OFF) // [R06]
        else $error("Delay circuit started without a rising mode bit");

    timer_run_a: assert property (dly_reg == hcd_pkg::HCD_DLY_RUN && drive_ctrl.delay_mode_bit
        |-> timer_run_bit[timer_sel]) // [R08]
        else $error("Selected timer not running during a delay");

    timer_pass_a: assert property (!drive_ctrl.delay_mode_bit
        |=> timer_run_bit == $past(software_timer_run)) // [R08]
        else $error("Timer run bits not passed through with delay off");

    delay_commit_a: assert property (dly_reg == hcd_pkg::HCD_DLY_RUN && match_sel
        && drive_ctrl.delay_mode_bit |=> delay_state_buffer_two_reg == $past(delay_state_buffer_one_reg)) // [R08]
        else $error("Compare match did not commit the delayed state");

    soft_select_a: assert property (!input_cfg.input_mode_select && !drive_ctrl.delay_mode_bit
        |-> decode_state == software_hall_bits) // [R01]
        else $error("Software Hall bits not selected");

    timer_owned_a: assert property (drive_ctrl.delay_mode_bit && dly_next != hcd_pkg::HCD_DLY_RUN
        |=> !timer_run_bit[$past(timer_sel)]) // [R08]
        else $error("Chosen timer ran with no delay pending");

    delay_off_a: assert property (!drive_ctrl.delay_mode_bit
        |=> dly_reg == hcd_pkg::HCD_DLY_OFF) // [R05]
        else $error("Delay circuit active with the mode bit low");

    valid_flag_a: assert property (hall_idx != `HCD_IDX_BAD
        |=> hall_state_valid) // [R19]
        else $error("Valid Hall state not flagged");

    pin_accept_a: assert property (sync2_reg == sync3_reg
        |=> pins_reg == $past(sync3_reg)) // [R01]
        else $error("Agreeing pin samples not accepted");

endmodule // hcd_top

// ### core/hcd_defines.svh
// Constants for the Hall commutation decoder: gate patterns, table bases, reset values.
// Assumes nothing else; included by bare name from the package and design files.
`ifndef HCD_DEFINES_SVH
`define HCD_DEFINES_SVH

`define HCD_HALL_W 3
`define HCD_GATE_W 6
`define HCD_TABLE_DEPTH 12
`define HCD_TIMER_COUNT 3
`define HCD_GATE_BRAKE 6'h15
`define HCD_GATE_OFF 6'h00
`define HCD_HALL_RESET 3'h0
`define HCD_BUF_RESET 3'h0
`define HCD_FWD_BASE 4'h0
`define HCD_BWD_BASE 4'h6
`define HCD_IDX_BAD 3'h7
`define HCD_PRESCALE_W 7
`define HCD_PRESCALE_RESET 7'h00
`define HCD_COUNT_RESET 5'h00
`define HCD_SYNC_RESET 6'h00
`define HCD_TIMER_RESET 3'h0
`define HCD_LAST_TIMER 2'h2

`endif

// ### core/hcd_pkg.sv
// Types and decode helpers shared by the Hall commutation decoder files.
// Assumes hcd_defines.svh is on the include path.
`include "hcd_defines.svh"

package hcd_pkg;

    typedef logic [`HCD_HALL_W-1:0] hcd_hall_t;
    typedef logic [`HCD_GATE_W-1:0] hcd_entry_t;
    typedef hcd_entry_t [`HCD_TABLE_DEPTH-1:0] hcd_table_t;

    // Bit order matches a table entry: bit5 is phase A top
    typedef struct packed {
        logic phase_a_top;
        logic phase_a_bottom;
        logic phase_b_top;
        logic phase_b_bottom;
        logic phase_c_top;
        logic phase_c_bottom;
    } hcd_gate_s;

    typedef struct packed {
        logic input_mode_select;
        logic filter_source_select;
        logic filter_enable;
        logic [2:0] filter_sample_rate_select;
        logic [4:0] filter_compare_count;
        logic sensor_120_select;
    } hcd_input_cfg_s;

    typedef struct packed {
        logic decoder_enable;
        logic rotation_direction;
        logic brake_force;
        logic protection_active;
        logic protection_brake_select;
        logic delay_mode_bit;
        logic [1:0] delay_timer_select;
    } hcd_drive_ctrl_s;

    typedef enum logic [2:0] {
        HCD_DLY_OFF = 3'h1,
        HCD_DLY_IDLE = 3'h2,
        HCD_DLY_RUN = 3'h4
    } hcd_dly_e;

    // Position of a Hall state in either table half, or the invalid code
    function automatic logic [2:0] hcd_hall_index(input hcd_hall_t s, input logic is120);
        logic [2:0] idx;
        idx = `HCD_IDX_BAD;
        if (is120) begin
            case (s)
                3'h4: idx = 3'h0;
                3'h6: idx = 3'h1;
                3'h2: idx = 3'h2;
                3'h3: idx = 3'h3;
                3'h1: idx = 3'h4;
                3'h5: idx = 3'h5;
                default: idx = `HCD_IDX_BAD;
            endcase
        end else begin
            case (s)
                3'h4: idx = 3'h0;
                3'h6: idx = 3'h1;
                3'h7: idx = 3'h2;
                3'h3: idx = 3'h3;
                3'h1: idx = 3'h4;
                3'h0: idx = 3'h5;
                default: idx = `HCD_IDX_BAD;
            endcase
        end
        return idx;
    endfunction

    function automatic logic [3:0] hcd_table_slot(input logic backward, input logic [2:0] idx);
        return (backward ? `HCD_BWD_BASE : `HCD_FWD_BASE) + {1'b0, idx};
    endfunction

endpackage

// ### core/hcd_noise_filter.sv
// Hall noise filter: samples at a selectable rate and accepts a state after N equal samples.
// Assumes its input is already synchronised to clk.
`timescale 1ns/1ps
`include "hcd_defines.svh"

module hcd_noise_filter (
    input wire logic clk,
    input wire logic reset,
    input wire hcd_pkg::hcd_hall_t raw,
    input wire logic enable,
    input wire logic [2:0] rate_select,
    input wire logic [4:0] compare_count,
    output hcd_pkg::hcd_hall_t filtered
);
    logic [`HCD_PRESCALE_W-1:0] prescale_reg, prescale_next;
    logic [4:0] count_reg, count_next;
    hcd_pkg::hcd_hall_t cand_reg, cand_next;
    hcd_pkg::hcd_hall_t out_reg, out_next;
    logic [`HCD_PRESCALE_W-1:0] mask;
    logic tick;
    logic [4:0] need;

    // Sample period is 2^rate_select clock cycles
    assign mask = `HCD_PRESCALE_W'((1 << rate_select) - 1);
    assign tick = (prescale_reg & mask) == mask;
    // A count of zero behaves as one comparison so the filter never locks up
    assign need = (compare_count == 5'h00) ? 5'h01 : compare_count;

    always_comb begin
        prescale_next = prescale_reg + 1'b1;
        count_next = count_reg;
        cand_next = cand_reg;
        out_next = out_reg;
        if (!enable) begin
            out_next = raw; // [R02]
            cand_next = raw;
            count_next = `HCD_COUNT_RESET;
        end else if (tick) begin // [R03]
            if (raw != cand_reg) begin
                cand_next = raw;
                count_next = `HCD_COUNT_RESET;
            end else if (count_reg + 5'h01 >= need) begin
                out_next = cand_reg; // [R04]
            end else begin
                count_next = count_reg + 5'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            prescale_reg <= `HCD_PRESCALE_RESET;
            count_reg <= `HCD_COUNT_RESET;
            cand_reg <= `HCD_HALL_RESET;
            out_reg <= `HCD_HALL_RESET;
        end else begin
            prescale_reg <= prescale_next;
            count_reg <= count_next;
            cand_reg <= cand_next;
            out_reg <= out_next;
        end
    end

    assign filtered = out_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    filter_bypass_a: assert property (!enable |=> filtered == $past(raw)) // [R02]
        else $error("Bypassed filter did not follow its input");
    filter_hold_a: assert property (enable && $past(enable) && $changed(filtered)
        |-> $past(tick) && $past(raw) == filtered) // [R04]
        else $error("Filtered state changed without a confirming sample");

endmodule // hcd_noise_filter

// ### dv/hcd_hall_sensor_model.sv
// Behavioural Hall sensor set with two sources, plus the three delay timers.
// Assumes step and bounce change just after a rising edge of clk.
`timescale 1ns/1ps

module hcd_hall_sensor_model #(
    parameter int DELAY_CYCLES = 12 // Kept well under one Hall step
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [2:0] step,
    input wire logic is120,
    input wire logic bounce,
    input wire logic [2:0] timer_run,
    output hcd_pkg::hcd_hall_t hall_main,
    output hcd_pkg::hcd_hall_t hall_alt,
    output logic [2:0] timer_match
);
    logic [7:0] cnt [3];

    function automatic hcd_pkg::hcd_hall_t st(input logic t120, input int idx);
        case (idx % 6)
            0: return 3'h4;
            1: return 3'h6;
            2: return t120 ? 3'h2 : 3'h7;
            3: return 3'h3;
            4: return 3'h1;
            default: return t120 ? 3'h5 : 3'h0;
        endcase
    endfunction

    // Bounce shows the next state, as switching noise on the sensor lines would
    assign hall_main = st(is120, bounce ? int'(step) + 1 : int'(step));
    // Second source sits half a cycle away so a source swap is visible
    assign hall_alt = st(is120, int'(step) + 3);

    // Counter clears on compare A match and only runs while its run bit is high, whether hardware or software holds it
    always_ff @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            if (reset || !timer_run[i]) begin
                cnt[i] <= 8'h00;
                timer_match[i] <= 1'b0;
            end else begin
                cnt[i] <= (cnt[i] == 8'(DELAY_CYCLES - 1)) ? 8'h00 : cnt[i] + 8'h01;
                timer_match[i] <= (cnt[i] == 8'(DELAY_CYCLES - 1));
            end
        end
    end
endmodule // hcd_hall_sensor_model

// ### dv/hcd_top_tb_top.sv
// Self-checking bench for the Hall commutation decoder top.
// Assumes hcd_pkg is compiled first and the sensor model is in dv/.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %0h got %0h", nm, e, g); end end

module hcd_top_tb_top;
    logic clk, reset, bounce;
    hcd_pkg::hcd_hall_t hall_inputs, hall_alt_inputs, sw_bits, buf_one, buf_two;
    hcd_pkg::hcd_input_cfg_s cfg;
    hcd_pkg::hcd_drive_ctrl_s drv;
    hcd_pkg::hcd_table_t tbl;
    hcd_pkg::hcd_gate_s gate;
    logic [2:0] sw_run, match, run_bits, step, m;
    logic valid;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    localparam logic [3:0] OVR [5] = '{4'h0, 4'h4, 4'hB, 4'hA, 4'hE};
    localparam logic [5:0] OVR_EXP [5] = '{6'h00, 6'h15, 6'h15, 6'h00, 6'h15};

    hcd_top i_hcd_top (.clk(clk), .reset(reset), .hall_inputs(hall_inputs),
        .hall_alt_inputs(hall_alt_inputs), .software_hall_bits(sw_bits), .input_cfg(cfg),
        .drive_ctrl(drv), .commutation_table_entries(tbl), .software_timer_run(sw_run),
        .timer_compare_match(match), .timer_run_bit(run_bits), .gate_controls(gate),
        .delay_state_buffer_one(buf_one), .delay_state_buffer_two(buf_two),
        .hall_state_valid(valid));

    hcd_hall_sensor_model i_hcd_hall_sensor_model (.clk(clk), .reset(reset), .step(step),
        .is120(cfg.sensor_120_select), .bounce(bounce), .timer_run(run_bits),
        .hall_main(hall_inputs), .hall_alt(hall_alt_inputs), .timer_match(match));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // A hang anywhere lands in the same closing report
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            final_report();
        end
    end

    task automatic final_report();
        if (failures == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    function automatic hcd_pkg::hcd_hall_t hs(input logic t120, input int idx);
        return i_hcd_hall_sensor_model.st(t120, idx);
    endfunction

    // Compare on the falling edge so every update of the rising edge has landed
    task automatic wait_chk(input int n, input logic [5:0] exp_gate);
        repeat (n) @(posedge clk);
        @(negedge clk);
        `CHK("gate_controls", exp_gate, gate)
    endtask

    initial begin
        reset = 1'b1;
        bounce = 1'b0;
        step = 3'h0;
        sw_bits = 3'h4;
        sw_run = 3'h5;
        cfg = '0;
        drv = '0;
        drv.delay_mode_bit = 1'b1;
        for (int i = 0; i < 12; i++)
            tbl[i] = 6'(i * 7 + 9);
        repeat (15) @(posedge clk);
        @(negedge clk);
        `CHK("reset buffers", 6'h00, {buf_one, buf_two})
        `CHK("reset run", 3'h0, run_bits)
        `CHK("reset valid", 1'b0, valid)
        @(posedge clk);
        reset <= 1'b0;
        drv.decoder_enable <= 1'b1;
        // Delay mode high out of reset never saw a rising edge
        @(posedge clk);
        sw_bits <= 3'h6;
        // Buffers held at zero decode as the last forward step in 60 degree mode
        wait_chk(6, tbl[5]);
        `CHK("no start valid", 1'b1, valid)
        `CHK("no start buffers", 6'h00, {buf_one, buf_two})
        `CHK("idle run bits", 3'h4, run_bits)
        @(posedge clk);
        drv.delay_mode_bit <= 1'b0;
        for (int t = 0; t < 2; t++) begin
            for (int d = 0; d < 2; d++) begin
                for (int k = 0; k < 6; k++) begin
                    @(posedge clk);
                    cfg.sensor_120_select <= t[0];
                    drv.rotation_direction <= d[0];
                    sw_bits <= hs(t[0], k);
                    wait_chk(3, tbl[d * 6 + k]);
                    `CHK("valid", 1'b1, valid)
                end
            end
            for (int k = 0; k < 2; k++) begin
                @(posedge clk);
                sw_bits <= t[0] ? (k == 0 ? 3'h7 : 3'h0) : (k == 0 ? 3'h5 : 3'h2);
                wait_chk(3, 6'h00);
                `CHK("invalid", 1'b0, valid)
            end
        end
        `CHK("low mode buffers", 6'h00, {buf_one, buf_two})
        @(posedge clk);
        cfg.sensor_120_select <= 1'b0;
        drv.rotation_direction <= 1'b0;
        sw_bits <= 3'h4;
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            {drv.decoder_enable, drv.brake_force, drv.protection_active,
                drv.protection_brake_select} <= OVR[k];
            wait_chk(3, OVR_EXP[k]);
        end
        @(posedge clk);
        {drv.decoder_enable, drv.brake_force, drv.protection_active,
            drv.protection_brake_select} <= 4'h8;
        cfg.input_mode_select <= 1'b1;
        step <= 3'h1;
        wait_chk(12, tbl[1]);
        @(posedge clk);
        cfg.filter_source_select <= 1'b1;
        wait_chk(12, tbl[4]);
        @(posedge clk);
        cfg.filter_source_select <= 1'b0;
        cfg.filter_enable <= 1'b1;
        cfg.filter_sample_rate_select <= 3'h2;
        cfg.filter_compare_count <= 5'h04;
        step <= 3'h2;
        wait_chk(60, tbl[2]);
        // A two-cycle glitch is far shorter than four samples four cycles apart
        @(posedge clk);
        bounce <= 1'b1;
        repeat (2) @(posedge clk);
        bounce <= 1'b0;
        wait_chk(40, tbl[2]);
        @(posedge clk);
        step <= 3'h3;
        wait_chk(6, tbl[2]);
        wait_chk(50, tbl[3]);
        @(posedge clk);
        cfg.filter_sample_rate_select <= 3'h0;
        step <= 3'h4;
        wait_chk(14, tbl[4]);
        @(posedge clk);
        cfg.filter_enable <= 1'b0;
        cfg.input_mode_select <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            m = 3'h1 << (s == 3 ? 2 : s);
            @(posedge clk);
            drv.decoder_enable <= 1'b0;
            drv.delay_mode_bit <= 1'b0;
            drv.delay_timer_select <= 2'(s);
            sw_bits <= 3'h4;
            @(posedge clk);
            drv.delay_mode_bit <= 1'b1;
            @(posedge clk);
            drv.decoder_enable <= 1'b1;
            wait_chk(3, tbl[0]);
            `CHK("init buffers", 6'h24, {buf_one, buf_two})
            @(posedge clk);
            sw_bits <= 3'h6;
            wait_chk(3, tbl[0]);
            `CHK("run bits busy", (sw_run & ~m) | m, run_bits)
            `CHK("held buffers", 6'h34, {buf_one, buf_two})
            wait_chk(20, tbl[1]);
            `CHK("run bits done", sw_run & ~m, run_bits)
            `CHK("moved buffers", 6'h36, {buf_one, buf_two})
        end
        final_report();
    end
endmodule // hcd_top_tb_top
